// ==== pkg/plc_exec_pkg.sv ====
package plc_exec_pkg;

	typedef enum logic [3:0] {
		op_real_power,
		op_float_round,
		op_clock_time_read,
		op_clock_time_write,
		op_calendar_read,
		op_calendar_write,
		op_bitwise_test_rung_open,
		op_bitwise_test_series,
		op_bitwise_test_parallel
	} op_t;

	typedef enum logic [1:0] {
		bt_and,
		bt_or,
		bt_xor
	} bt_fn_t;

	// Timekeeping base: one second of core clocks
	localparam int unsigned SEC_PERIOD_NS     = 1000000000;
	localparam int unsigned CLK_PERIOD_NS     = 40;
	localparam int unsigned TICKS_PER_SEC_DEF = SEC_PERIOD_NS / CLK_PERIOD_NS;

	// Field limits of the clock and calendar
	localparam logic [15:0] SEC_MAX  = 16'h003b;
	localparam logic [15:0] MIN_MAX  = 16'h003b;
	localparam logic [15:0] HR_MAX   = 16'h0017;
	localparam logic [15:0] DAY_MIN  = 16'h0001;
	localparam logic [15:0] DAY_MAX  = 16'h001f;
	localparam logic [15:0] MON_MIN  = 16'h0001;
	localparam logic [15:0] MON_MAX  = 16'h000c;
	localparam logic [15:0] YR_MIN   = 16'h0015;
	localparam logic [15:0] YR_MAX   = 16'h0063;
	localparam logic [7:0]  FEB_DAYS       = 8'h1c;
	localparam logic [7:0]  FEB_LEAP_DAYS  = 8'h1d;
	localparam logic [7:0]  SHORT_DAYS     = 8'h1e;
	localparam logic [7:0]  LONG_DAYS      = 8'h1f;

	// Values after reset: 00:00:00 on day 1, month 1, year 21
	localparam logic [7:0]  RST_SEC  = 8'h00;
	localparam logic [7:0]  RST_MIN  = 8'h00;
	localparam logic [7:0]  RST_HR   = 8'h00;
	localparam logic [7:0]  RST_DAY  = 8'h01;
	localparam logic [7:0]  RST_MON  = 8'h01;
	localparam logic [7:0]  RST_YR   = 8'h15;

	// Single-precision encodings and exponent landmarks
	localparam logic [31:0] F_ONE  = 32'h3f800000;
	localparam logic [31:0] F_INF  = 32'h7f800000;
	localparam logic [31:0] F_NAN  = 32'h7fc00000;
	localparam logic [31:0] F_ZERO = 32'h00000000;
	localparam logic [7:0]  F_BIAS       = 8'h7f;
	localparam logic [7:0]  F_EXP_SPECIAL = 8'hff;
	localparam logic [7:0]  POW_INT_EXP  = 8'h96;
	localparam logic [7:0]  ROUND_HALF_EXP = 8'h7e;
	localparam logic [7:0]  ROUND_FIX_EXP  = 8'h95;
	localparam logic [7:0]  ROUND_SAT_EXP  = 8'h9e;
	localparam logic [31:0] INT16_MAX = 32'h00007fff;
	localparam logic [31:0] INT32_MAX = 32'h7fffffff;
	localparam logic signed [63:0] POW_N_MAX = 64'sh7f;
	localparam logic signed [63:0] POW_N_MIN = -64'sh7e;
	localparam logic [3:0]  POW_LAST_STEP = 4'hf;

endpackage

// ==== pkg/rtc_if.sv ====
`timescale 1ns/10ps
interface rtc_if;
	logic [7:0] sec;
	logic [7:0] minute;
	logic [7:0] hour;
	logic [7:0] day;
	logic [7:0] month;
	logic [7:0] year;
	logic       set_time;
	logic       set_date;
	logic [7:0] wd0;
	logic [7:0] wd1;
	logic [7:0] wd2;

	modport keeper (
		input  set_time, set_date, wd0, wd1, wd2,
		output sec, minute, hour, day, month, year
	);
	modport user (
		output set_time, set_date, wd0, wd1, wd2,
		input  sec, minute, hour, day, month, year
	);
endinterface

// ==== src/rtc_keeper.sv ====
`timescale 1ns/10ps
module rtc_keeper
	import plc_exec_pkg::*;
#(
	parameter int unsigned TICKS_PER_SEC = TICKS_PER_SEC_DEF
) (
	input wire logic core_clk,
	input wire logic arst_n,
	rtc_if.keeper    rtc
);

	logic [31:0] tick_r;
	logic        sec_tick;
	logic        day_end;

	// Years 21..99 all lie in one century, so every fourth is a leap year
	function automatic logic [7:0] month_days(input logic [7:0] mon,
		input logic [7:0] yr);
		case (mon)
			8'h02:                      month_days = (yr[1:0] == 2'b00) ?
				FEB_LEAP_DAYS : FEB_DAYS;
			8'h04, 8'h06, 8'h09, 8'h0b: month_days = SHORT_DAYS;
			default:                    month_days = LONG_DAYS;
		endcase
	endfunction

	assign sec_tick = (tick_r == 32'(TICKS_PER_SEC - 1));
	assign day_end  = sec_tick && (rtc.sec == SEC_MAX[7:0])
		&& (rtc.minute == MIN_MAX[7:0]) && (rtc.hour == HR_MAX[7:0]);

	// Setting the time restarts the current second
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_r <= '0;
		end else if (rtc.set_time || sec_tick) begin
			tick_r <= '0;
		end else begin
			tick_r <= tick_r + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtc.sec    <= RST_SEC;
			rtc.minute <= RST_MIN;
			rtc.hour   <= RST_HR;
		end else if (rtc.set_time) begin
			rtc.sec    <= rtc.wd0;
			rtc.minute <= rtc.wd1;
			rtc.hour   <= rtc.wd2;
		end else if (sec_tick) begin
			if (rtc.sec == SEC_MAX[7:0]) begin
				rtc.sec <= RST_SEC;
				if (rtc.minute == MIN_MAX[7:0]) begin
					rtc.minute <= RST_MIN;
					rtc.hour   <= (rtc.hour == HR_MAX[7:0]) ?
						RST_HR : rtc.hour + 8'h01;
				end else begin
					rtc.minute <= rtc.minute + 8'h01;
				end
			end else begin
				rtc.sec <= rtc.sec + 8'h01;
			end
		end
	end

	// Past year 99 the calendar wraps to the first year it can hold
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rtc.day   <= RST_DAY;
			rtc.month <= RST_MON;
			rtc.year  <= RST_YR;
		end else if (rtc.set_date) begin
			rtc.day   <= rtc.wd0;
			rtc.month <= rtc.wd1;
			rtc.year  <= rtc.wd2;
		end else if (day_end) begin
			if (rtc.day >= month_days(rtc.month, rtc.year)) begin
				rtc.day <= RST_DAY;
				if (rtc.month == MON_MAX[7:0]) begin
					rtc.month <= RST_MON;
					rtc.year  <= (rtc.year == YR_MAX[7:0]) ?
						YR_MIN[7:0] : rtc.year + 8'h01;
				end else begin
					rtc.month <= rtc.month + 8'h01;
				end
			end else begin
				rtc.day <= rtc.day + 8'h01;
			end
		end
	end

endmodule

// ==== src/plc_exec_unit.sv ====
`timescale 1ns/10ps
module plc_exec_unit
	import plc_exec_pkg::*;
#(
	parameter int unsigned TICKS_PER_SEC = TICKS_PER_SEC_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        op_start,
	input  wire op_t         op_sel,
	input  wire bt_fn_t      bt_fn,
	input  wire logic        op_dword,
	input  wire logic [15:0] a_w0,
	input  wire logic [15:0] a_w1,
	input  wire logic [15:0] a_w2,
	input  wire logic [15:0] b_w0,
	input  wire logic [15:0] b_w1,
	input  wire logic        rung_in,
	output logic             busy,
	output logic             done,
	output logic             dst_wr,
	output logic [1:0]       dst_cnt,
	output logic [15:0]      dst_w0,
	output logic [15:0]      dst_w1,
	output logic [15:0]      dst_w2,
	output logic             contact,
	output logic             rung_out,
	output logic             op_err
);

	typedef enum {st_idle, st_log, st_scale, st_exp, st_finish} state_t;

	state_t             state_r;
	logic [31:0]        pb_r;
	logic [23:0]        m_r;
	logic signed [23:0] logv_r;
	logic [15:0]        frac_r;
	logic signed [8:0]  expn_r;
	logic [3:0]         cnt_r;
	logic               spec_r;
	logic [31:0]        spec_res_r;
	logic               pow_err_r;
	logic [31:0]        a32;
	logic [31:0]        b32;
	logic [23:0]        mul_b;
	logic [47:0]        prod;
	logic signed [63:0] sprod;
	logic signed [63:0] y;
	logic signed [63:0] y_top;
	logic [31:0]        pow_res;
	logic [31:0]        rnd;
	logic               bt_hit;
	logic               take;
	logic               done_r;
	logic               dst_wr_r;
	logic [1:0]         dst_cnt_r;
	logic [15:0]        dst_w0_r;
	logic [15:0]        dst_w1_r;
	logic [15:0]        dst_w2_r;
	logic               contact_r;
	logic               rung_out_r;
	logic               op_err_r;
	logic               set_time_r;
	logic               set_date_r;
	logic [7:0]         wd0_r;
	logic [7:0]         wd1_r;
	logic [7:0]         wd2_r;

	rtc_if rtc_link ();

	rtc_keeper #(
		.TICKS_PER_SEC (TICKS_PER_SEC)
	) u_rtc (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.rtc      (rtc_link.keeper)
	);

	// Fractional part of 2^(2^-(k+1)) in Q1.23, for the exp2 product
	function automatic logic [22:0] exp2_step(input logic [3:0] k);
		case (k)
			4'h0:    exp2_step = 23'h3504f3;
			4'h1:    exp2_step = 23'h1837f0;
			4'h2:    exp2_step = 23'h0b95c2;
			4'h3:    exp2_step = 23'h05aac3;
			4'h4:    exp2_step = 23'h02cd87;
			4'h5:    exp2_step = 23'h0164d2;
			4'h6:    exp2_step = 23'h00b1ed;
			4'h7:    exp2_step = 23'h0058d8;
			4'h8:    exp2_step = 23'h002c64;
			4'h9:    exp2_step = 23'h001630;
			4'ha:    exp2_step = 23'h000b18;
			4'hb:    exp2_step = 23'h00058c;
			4'hc:    exp2_step = 23'h0002c6;
			4'hd:    exp2_step = 23'h000163;
			4'he:    exp2_step = 23'h0000b1;
			default: exp2_step = 23'h000059;
		endcase
	endfunction

	// Half-way cases round away from zero; saturates symmetrically
	function automatic logic [31:0] f2int(input logic [31:0] f,
		input logic dw);
		logic [7:0]  e;
		logic [39:0] v;
		logic [31:0] lim;
		logic [31:0] mag;
		e   = f[30:23];
		lim = dw ? INT32_MAX : INT16_MAX;
		v   = '0;
		mag = '0;
		if (e >= ROUND_SAT_EXP) begin
			mag = lim;
		end else if (e >= ROUND_HALF_EXP) begin
			if (e >= ROUND_FIX_EXP) begin
				v = {16'h0, 1'b1, f[22:0]} << (e - ROUND_FIX_EXP);
			end else begin
				v = {16'h0, 1'b1, f[22:0]} >> (ROUND_FIX_EXP - e);
			end
			v   = v + 40'h1;
			mag = (v[39:33] != 7'h0) ? lim : v[32:1];
			if (mag > lim) begin
				mag = lim;
			end
		end
		f2int = f[31] ? (32'h0 - mag) : mag;
	endfunction

	function automatic logic time_ok(input logic [15:0] s,
		input logic [15:0] m, input logic [15:0] h);
		time_ok = (s <= SEC_MAX) && (m <= MIN_MAX) && (h <= HR_MAX);
	endfunction

	function automatic logic date_ok(input logic [15:0] d,
		input logic [15:0] m, input logic [15:0] y);
		date_ok = (d >= DAY_MIN) && (d <= DAY_MAX) && (m >= MON_MIN)
			&& (m <= MON_MAX) && (y >= YR_MIN) && (y <= YR_MAX);
	endfunction

	// Operands arrive as register pairs, lower register holds bits 15:0
	assign a32  = {a_w1, a_w0};
	assign b32  = {b_w1, b_w0};
	assign take = op_start && (state_r == st_idle);
	assign busy = (state_r != st_idle);

	// One shared multiplier: squaring for log2, scaling for exp2
	assign mul_b = (state_r == st_exp) ? {1'b1, exp2_step(cnt_r)} : m_r;
	assign prod  = 48'(m_r) * 48'(mul_b);

	always_comb begin
		sprod = $signed({{40{logv_r[23]}}, logv_r})
			* $signed({40'h0, 1'b1, pb_r[22:0]});
		if (pb_r[31]) begin
			sprod = -sprod;
		end
		y     = sprod >>> (POW_INT_EXP - pb_r[30:23]);
		y_top = y >>> 16;
	end

	always_comb begin
		logic [31:0] r;
		r = '0;
		case (bt_fn)
			bt_and:  r = a32 & b32;
			bt_or:   r = a32 | b32;
			bt_xor:  r = a32 ^ b32;
			default: r = '0;
		endcase
		if (!op_dword) begin
			r[31:16] = 16'h0;
		end
		bt_hit = (r != 32'h0);
	end

	assign rnd     = f2int(a32, op_dword);
	assign pow_res = spec_r ? spec_res_r
		: {1'b0, 8'(expn_r + 9'sh07f), m_r[22:0]};

	// Power as 2^(b*log2 a): 16 squaring steps, one scale, 16 exp steps.
	// Negative bases with a nonzero exponent are refused rather than guessing integer exponents.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r    <= st_idle;
			pb_r       <= '0;
			m_r        <= '0;
			logv_r     <= '0;
			frac_r     <= '0;
			expn_r     <= '0;
			cnt_r      <= '0;
			spec_r     <= 1'b0;
			spec_res_r <= '0;
			pow_err_r  <= 1'b0;
		end else begin
			case (state_r)
				st_idle: begin
					if (take && op_sel == op_real_power) begin
						pb_r      <= b32;
						m_r       <= {1'b1, a32[22:0]};
						logv_r    <= {8'(a32[30:23] - F_BIAS), 16'h0};
						cnt_r     <= '0;
						spec_r    <= 1'b1;
						pow_err_r <= 1'b0;
						state_r   <= st_finish;
						if (b32[30:0] == 31'h0) begin
							spec_res_r <= F_ONE;
						end else if (a32[30:0] == 31'h0) begin
							spec_res_r <= b32[31] ? F_INF : F_ZERO;
						end else if (a32[31]
							|| a32[30:23] == F_EXP_SPECIAL) begin
							spec_res_r <= F_NAN;
							pow_err_r  <= 1'b1;
						end else begin
							spec_r  <= 1'b0;
							state_r <= st_log;
						end
					end
				end
				st_log: begin
					if (prod[47]) begin
						m_r                   <= prod[47:24];
						logv_r[4'hf - cnt_r] <= 1'b1;
					end else begin
						m_r <= prod[46:23];
					end
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == POW_LAST_STEP) begin
						state_r <= st_scale;
					end
				end
				st_scale: begin
					cnt_r <= '0;
					m_r   <= {1'b1, 23'h0};
					if (pb_r[30:23] >= POW_INT_EXP && logv_r != 24'sh0) begin
						spec_r     <= 1'b1;
						spec_res_r <= (sprod < 0) ? F_ZERO : F_INF;
						state_r    <= st_finish;
					end else if (y_top > POW_N_MAX) begin
						spec_r     <= 1'b1;
						spec_res_r <= F_INF;
						state_r    <= st_finish;
					end else if (y_top < POW_N_MIN) begin
						spec_r     <= 1'b1;
						spec_res_r <= F_ZERO;
						state_r    <= st_finish;
					end else begin
						expn_r  <= y_top[8:0];
						frac_r  <= y[15:0];
						state_r <= st_exp;
					end
				end
				st_exp: begin
					if (frac_r[4'hf - cnt_r]) begin
						m_r <= prod[46:23];
					end
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == POW_LAST_STEP) begin
						state_r <= st_finish;
					end
				end
				st_finish: begin
					state_r <= st_idle;
				end
				default: begin
					state_r <= st_idle;
				end
			endcase
		end
	end

	// Results and contacts; the caller writes dst words back, so a
	// destination equal to a source is simply overwritten each scan.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_r     <= 1'b0;
			dst_wr_r   <= 1'b0;
			dst_cnt_r  <= '0;
			dst_w0_r   <= '0;
			dst_w1_r   <= '0;
			dst_w2_r   <= '0;
			contact_r  <= 1'b0;
			rung_out_r <= 1'b0;
			op_err_r   <= 1'b0;
		end else begin
			done_r   <= 1'b0;
			dst_wr_r <= 1'b0;
			op_err_r <= 1'b0;
			if (state_r == st_finish) begin
				dst_w0_r  <= pow_res[15:0];
				dst_w1_r  <= pow_res[31:16];
				dst_w2_r  <= '0;
				dst_cnt_r <= 2'h2;
				dst_wr_r  <= 1'b1;
				done_r    <= 1'b1;
				op_err_r  <= pow_err_r;
			end else if (take && op_sel != op_real_power) begin
				done_r <= 1'b1;
				case (op_sel)
					op_float_round: begin
						dst_w0_r  <= rnd[15:0];
						dst_w1_r  <= op_dword ? rnd[31:16] : 16'h0;
						dst_w2_r  <= '0;
						dst_cnt_r <= op_dword ? 2'h2 : 2'h1;
						dst_wr_r  <= 1'b1;
					end
					op_clock_time_read: begin
						dst_w0_r  <= {8'h0, rtc_link.sec};
						dst_w1_r  <= {8'h0, rtc_link.minute};
						dst_w2_r  <= {8'h0, rtc_link.hour};
						dst_cnt_r <= 2'h3;
						dst_wr_r  <= 1'b1;
					end
					op_calendar_read: begin
						dst_w0_r  <= {8'h0, rtc_link.day};
						dst_w1_r  <= {8'h0, rtc_link.month};
						dst_w2_r  <= {8'h0, rtc_link.year};
						dst_cnt_r <= 2'h3;
						dst_wr_r  <= 1'b1;
					end
					op_clock_time_write: begin
						op_err_r <= !time_ok(a_w0, a_w1, a_w2);
					end
					op_calendar_write: begin
						op_err_r <= !date_ok(a_w0, a_w1, a_w2);
					end
					op_bitwise_test_rung_open: begin
						contact_r  <= bt_hit;
						rung_out_r <= bt_hit;
					end
					op_bitwise_test_series: begin
						contact_r  <= bt_hit;
						rung_out_r <= rung_in & bt_hit;
					end
					op_bitwise_test_parallel: begin
						contact_r  <= bt_hit;
						rung_out_r <= rung_in | bt_hit;
					end
					default: begin
						done_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// Clock loads happen only after the whole triple passes its check
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			set_time_r <= 1'b0;
			set_date_r <= 1'b0;
			wd0_r      <= '0;
			wd1_r      <= '0;
			wd2_r      <= '0;
		end else begin
			set_time_r <= take && op_sel == op_clock_time_write
				&& time_ok(a_w0, a_w1, a_w2);
			set_date_r <= take && op_sel == op_calendar_write
				&& date_ok(a_w0, a_w1, a_w2);
			if (take) begin
				wd0_r <= a_w0[7:0];
				wd1_r <= a_w1[7:0];
				wd2_r <= a_w2[7:0];
			end
		end
	end

	assign rtc_link.set_time = set_time_r;
	assign rtc_link.set_date = set_date_r;
	assign rtc_link.wd0      = wd0_r;
	assign rtc_link.wd1      = wd1_r;
	assign rtc_link.wd2      = wd2_r;

	assign done     = done_r;
	assign dst_wr   = dst_wr_r;
	assign dst_cnt  = dst_cnt_r;
	assign dst_w0   = dst_w0_r;
	assign dst_w1   = dst_w1_r;
	assign dst_w2   = dst_w2_r;
	assign contact  = contact_r;
	assign rung_out = rung_out_r;
	assign op_err   = op_err_r;

endmodule

// ==== verification/plc_exec_properties.sv ====
`timescale 1ns/10ps
module plc_exec_properties
	import plc_exec_pkg::*;
#(
	parameter int unsigned TICKS_PER_SEC = TICKS_PER_SEC_DEF
) (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        op_start,
	input wire op_t         op_sel,
	input wire bt_fn_t      bt_fn,
	input wire logic        op_dword,
	input wire logic [15:0] a_w0,
	input wire logic [15:0] a_w1,
	input wire logic [15:0] a_w2,
	input wire logic [15:0] b_w0,
	input wire logic [15:0] b_w1,
	input wire logic        rung_in,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        dst_wr,
	input wire logic [1:0]  dst_cnt,
	input wire logic [15:0] dst_w0,
	input wire logic [15:0] dst_w1,
	input wire logic [15:0] dst_w2,
	input wire logic        contact,
	input wire logic        rung_out,
	input wire logic        op_err
);
	logic [31:0] res;
	logic        hit;
	logic        take;
	assign take = op_start && !busy;
	always_comb begin
		case (bt_fn)
			bt_and:  res = {a_w1, a_w0} & {b_w1, b_w0};
			bt_or:   res = {a_w1, a_w0} | {b_w1, b_w0};
			default: res = {a_w1, a_w0} ^ {b_w1, b_w0};
		endcase
	end
	// Single form must ignore the upper words entirely
	assign hit = op_dword ? (res != 32'h0) : (res[15:0] != 16'h0);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_pow_go;
		take && op_sel == op_real_power;
	endsequence
	sequence s_pow_end;
		##[2:35] (done && dst_wr && dst_cnt == 2'h2) ##1 !busy;
	endsequence
	a_pow_busy: assert property (s_pow_go |=> busy)
		else $error("power step not busy");
	a_pow_finish: assert property (s_pow_go |-> s_pow_end)
		else $error("power result not written in time");
	a_err_done: assert property (op_err |-> done)
		else $error("error pulse without done");
	a_wr_done: assert property (dst_wr |-> done)
		else $error("write pulse without done");
	a_bt_contact: assert property (take && op_sel inside {op_bitwise_test_rung_open,
		op_bitwise_test_series, op_bitwise_test_parallel}
		|=> done && !dst_wr && contact == $past(hit)) else $error("bad contact");
	a_rung_open: assert property (take && op_sel == op_bitwise_test_rung_open
		|=> rung_out == contact) else $error("rung open not contact");
	a_series_and: assert property (take && op_sel == op_bitwise_test_series
		|=> rung_out == (contact && $past(rung_in))) else $error("bad series");
	a_par_or: assert property (take && op_sel == op_bitwise_test_parallel
		|=> rung_out == (contact || $past(rung_in))) else $error("bad parallel");
	a_round_cnt: assert property (take && op_sel == op_float_round
		|=> dst_wr && dst_cnt == ($past(op_dword) ? 2'h2 : 2'h1))
		else $error("round word count wrong");
	a_read_cnt: assert property (take && op_sel inside {op_clock_time_read,
		op_calendar_read} |=> dst_wr && dst_cnt == 2'h3) else $error("read count");
	a_time_range: assert property (take && op_sel == op_clock_time_read
		|=> dst_w0 <= SEC_MAX && dst_w1 <= MIN_MAX && dst_w2 <= HR_MAX)
		else $error("time field out of range");
	a_write_quiet: assert property (take && op_sel inside {op_clock_time_write,
		op_calendar_write} |=> done && !dst_wr) else $error("write gave data");
	a_bad_time: assert property (take && op_sel == op_clock_time_write
		&& (a_w0 > SEC_MAX || a_w1 > MIN_MAX || a_w2 > HR_MAX) |=> op_err)
		else $error("bad time accepted");
	a_bad_date: assert property (take && op_sel == op_calendar_write
		&& !(a_w0 inside {[DAY_MIN:DAY_MAX]}
		&& a_w1 inside {[MON_MIN:MON_MAX]}
		&& a_w2 inside {[YR_MIN:YR_MAX]}) |=> op_err)
		else $error("bad date accepted");
endmodule

bind plc_exec_unit plc_exec_properties #(.TICKS_PER_SEC(TICKS_PER_SEC))
	u_plc_exec_properties (.core_clk(core_clk), .arst_n(arst_n),
	.op_start(op_start), .op_sel(op_sel), .bt_fn(bt_fn), .op_dword(op_dword),
	.a_w0(a_w0), .a_w1(a_w1), .a_w2(a_w2), .b_w0(b_w0), .b_w1(b_w1),
	.rung_in(rung_in), .busy(busy), .done(done), .dst_wr(dst_wr),
	.dst_cnt(dst_cnt), .dst_w0(dst_w0), .dst_w1(dst_w1), .dst_w2(dst_w2),
	.contact(contact), .rung_out(rung_out), .op_err(op_err));

// ==== verification/test_plc_exec_unit.sv ====
`timescale 1ns/10ps
module test_plc_exec_unit;
	import plc_exec_pkg::*;
	// kind: 0 no data, 1 data words, 2 power high word only, 3 bit test
	typedef struct {
		logic [1:0]  kind;
		logic [1:0]  cnt;
		logic [15:0] w0, w1, w2;
		logic        c, r, e;
	} note_t;
	logic        core_clk = 1'b0;
	logic        arst_n   = 1'b0;
	logic        op_start = 1'b0;
	op_t         op_sel   = op_real_power;
	bt_fn_t      bt_fn    = bt_and;
	logic        op_dword = 1'b0;
	logic [15:0] a_w0 = '0, a_w1 = '0, a_w2 = '0, b_w0 = '0, b_w1 = '0;
	logic        rung_in  = 1'b0;
	logic        busy, done, dst_wr, contact, rung_out, op_err;
	logic [1:0]  dst_cnt;
	logic [15:0] dst_w0, dst_w1, dst_w2;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          seed       = 72600;
	note_t       q[$];
	note_t       n;
	logic [31:0] a, b, res;
	logic        c_exp, r_exp, r_in;
	logic [47:0] bad [9] = '{48'h003c_0000_0000, 48'h0000_003c_0000,
		48'h0000_0000_0018, 48'h0000_0001_0015, 48'h0020_0001_0015,
		48'h0001_0000_0015, 48'h0001_000d_0015, 48'h0001_0001_0014,
		48'h0001_0001_0064};
	logic [64:0] rnd [7] = '{{1'b0, 32'h40200000, 32'h3}, {1'b0, 32'h3fb33333,
		32'h1}, {1'b0, 32'hc0200000, 32'hfffd}, {1'b1, 32'h47c35000, 32'h186a0},
		{1'b1, 32'h4f000000, 32'h7fffffff}, {1'b0, 32'h47000000, 32'h7fff},
		{1'b1, 32'h00000002, 32'h0}};

	plc_exec_unit #(.TICKS_PER_SEC(10)) u_plc_exec_unit (
		.core_clk(core_clk), .arst_n(arst_n), .op_start(op_start),
		.op_sel(op_sel), .bt_fn(bt_fn), .op_dword(op_dword), .a_w0(a_w0),
		.a_w1(a_w1), .a_w2(a_w2), .b_w0(b_w0), .b_w1(b_w1),
		.rung_in(rung_in), .busy(busy), .done(done), .dst_wr(dst_wr),
		.dst_cnt(dst_cnt), .dst_w0(dst_w0), .dst_w1(dst_w1),
		.dst_w2(dst_w2), .contact(contact), .rung_out(rung_out),
		.op_err(op_err));

	always #20 core_clk = ~core_clk;

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Leaves op_start high so the next call issues back to back
	task automatic go(op_t op, logic dw, logic [15:0] a0, a1, a2, b0, b1,
		note_t nt);
		op_start <= 1'b1;
		op_sel <= op;
		op_dword <= dw;
		a_w0 <= a0;
		a_w1 <= a1;
		a_w2 <= a2;
		b_w0 <= b0;
		b_w1 <= b1;
		q.push_back(nt);
		@(posedge core_clk);
	endtask

	task automatic idle(int k);
		op_start <= 1'b0;
		repeat (k) @(posedge core_clk);
	endtask

	task automatic rst();
		arst_n <= 1'b0;
		idle(6);
		arst_n <= 1'b1;
	endtask

	task automatic rd(op_t op, logic [15:0] x, y, z);
		go(op, 0, 0, 0, 0, 0, 0, '{1, 3, x, y, z, 0, 0, 0});
	endtask

	task automatic wr(op_t op, logic [15:0] x, y, z, logic e);
		go(op, 0, x, y, z, 0, 0, '{0, 0, 0, 0, 0, 0, 0, e});
	endtask

	task automatic pw(logic [31:0] x, y, logic [1:0] k, logic [31:0] r, logic e);
		go(op_real_power, 1, x[15:0], x[31:16], 0, y[15:0], y[31:16],
			'{k, 2, r[15:0], r[31:16], 0, 0, 0, e});
		idle(40);
	endtask

	// Results are judged when done is settled, away from the driving edge
	always @(negedge core_clk) begin
		if (done === 1'b1) begin
			if (q.size() == 0) begin
				chk("unexpected done", 1, 0);
			end else begin
				n = q.pop_front();
				chk("op_err", op_err, n.e);
				chk("dst_wr", dst_wr, n.kind inside {1, 2});
				if (n.kind == 1) begin
					chk("dst_cnt", dst_cnt, n.cnt);
					chk("dst_w0", dst_w0, n.w0);
					if (n.cnt > 1) chk("dst_w1", dst_w1, n.w1);
					if (n.cnt > 2) chk("dst_w2", dst_w2, n.w2);
				end
				if (n.kind == 2) chk("pow_hi", dst_w1, n.w1);
				if (n.kind == 3) begin
					chk("contact", contact, n.c);
					chk("rung_out", rung_out, n.r);
				end
			end
		end
	end

	initial begin
		#(40 * 3000);
		fail_count++;
		test_done();
	end

	initial begin
		rst();
		rd(op_clock_time_read, 0, 0, 0);
		rd(op_calendar_read, 1, 1, 16'h15);
		wr(op_clock_time_write, 16'h2a, 16'h0b, 16'h03, 0);
		wr(op_calendar_write, 16'h04, 16'h02, 16'h16, 0);
		for (int i = 0; i < 9; i++)
			wr(i < 3 ? op_clock_time_write : op_calendar_write,
				bad[i][47:32], bad[i][31:16], bad[i][15:0], 1);
		rd(op_clock_time_read, 16'h2a, 16'h0b, 16'h03);
		rd(op_calendar_read, 16'h04, 16'h02, 16'h16);
		// Counting carries through every field at its upper limit
		wr(op_calendar_write, 16'h1f, 16'h0c, 16'h63, 0);
		wr(op_clock_time_write, 16'h3b, 16'h3b, 16'h17, 0);
		idle(14);
		rd(op_clock_time_read, 0, 0, 0);
		rd(op_calendar_read, 1, 1, 16'h15);
		for (int i = 0; i < 7; i++)
			go(op_float_round, rnd[i][64], rnd[i][47:32], rnd[i][63:48], 16'h5a5a,
				0, 0, '{1, rnd[i][64] ? 2 : 1, rnd[i][15:0], rnd[i][31:16],
				0, 0, 0, 0});
		for (int i = 0; i < 36; i++) begin
			a = (i % 5 == 0) ? 32'h0 : $random(seed);
			b = (i % 5 == 0) ? 32'h0 : (i % 3 == 2) ? {a[31:16], ~a[15:0]} :
				(i % 2) ? a : ~a;
			r_in = 1'($random(seed));
			case ((i / 3) % 3)
				0: res = a & b;
				1: res = a | b;
				default: res = a ^ b;
			endcase
			c_exp = ((i / 9) % 2) ? (res != 0) : (res[15:0] != 0);
			r_exp = (i % 3 == 0) ? c_exp : (i % 3 == 1) ? (r_in & c_exp) :
				(r_in | c_exp);
			// Qualifiers change with the request, never under a standing one
			bt_fn <= bt_fn_t'((i / 3) % 3);
			rung_in <= r_in;
			go(op_t'(6 + i % 3), (i / 9) % 2, a[15:0], a[31:16], 0, b[15:0],
				b[31:16], '{3, 0, 0, 0, 0, c_exp, r_exp, 0});
		end
		idle(2);
		pw(32'h40000000, 32'h40400000, 2, 32'h41000000, 0);
		go(op_real_power, 1, 0, 0, 0, 0, 0, '{1, 2, 0, 16'h3f80, 0, 0, 0, 0});
		idle(5);
		// A request while busy must be dropped without an answer
		go(op_real_power, 1, 16'h0, 16'h4080, 0, 16'h0, 16'h3f00,
			'{2, 2, 0, 16'h4000, 0, 0, 0, 0});
		op_sel <= op_bitwise_test_rung_open;
		repeat (5) @(posedge core_clk);
		idle(40);
		pw(32'hc0000000, 32'h40000000, 1, F_NAN, 1);
		pw(32'h00000000, 32'hbf800000, 1, F_INF, 0);
		rst();
		rd(op_clock_time_read, 0, 0, 0);
		idle(3);
		chk("pending", q.size(), 0);
		test_done();
	end
endmodule
